// ===== rtl/supply_ctl_pkg.sv
// Constants for the serial control path of a programmable supply.
// Assumes both ends run on one 100 MHz system clock of their own.
package supply_ctl_pkg;
  // ==========================================================
  // Control word layout
  localparam int WORD_W = 18;
  localparam int CNT_W = 5;
  localparam int BIT_XFER_ACTIVE = 0;
  localparam int BIT_XFER_INPUT = 1;
  localparam int BIT_CMP_FLOAT_N = 6;
  localparam int BIT_MEAS_FLOAT_N = 7;
  localparam int BIT_FORCE_FLOAT_N = 8;
  localparam int BIT_CLAMP_EN = 10;
  localparam int BIT_RANGE_LO = 11;
  localparam int BIT_RANGE_HI = 13;
  localparam int BIT_FORCE_KIND = 17;
  localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int HALF_SCLK_NS = 80;
  localparam int HALF_SCLK_CYC = HALF_SCLK_NS / CLK_NS;
  localparam int CS_GAP_NS = 100;
  localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIM_W = 4;
  localparam logic [TIM_W-1:0] HALF_SCLK_TOP = TIM_W'(HALF_SCLK_CYC - 1);
  localparam logic [TIM_W-1:0] CS_GAP_TOP = TIM_W'(CS_GAP_CYC - 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);
endpackage

// ===== rtl/supply_link_if.sv
// Four-wire serial link plus load strobe between host and supply.
// Assumes the bench joins the two modports; no clocking block here.
`timescale 1ns/1ps
interface supply_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic load_n;
  modport host (output sclk, output cs_n, output sdi, output load_n,
                input sdo);
  modport dev (input sclk, input cs_n, input sdi, input load_n,
               output sdo);
endinterface

// ===== rtl/sync2.sv
// Two-flop synchroniser for a bundle of link, float or thermal pins.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } st_t;
  st_t st_r;
  st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule

// ===== rtl/supply_dev.sv
// Device end: shift, input and active control registers of the supply.
// Assumes link pins are asynchronous; they are sampled by clk.
`timescale 1ns/1ps
module supply_dev
  import supply_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  supply_link_if.dev link,
  input wire logic measure_float_pin_n,
  input wire logic temp_warn_band,
  input wire logic temp_over,
  output logic [WORD_W-1:0] active_word,
  output logic clamp_volt_en,
  output logic clamp_curr_en,
  output logic cmp_out_en,
  output logic meas_out_en,
  output logic [2:0] range_sel,
  output logic external_amp_select,
  output logic [1:0] force_kind_select,
  output logic thermal_warning_n,
  output logic thermal_tripped
);
  typedef enum logic [1:0] {
    MODE_HIZ = 2'h0,
    MODE_SLAVE = 2'h1,
    MODE_VOLT = 2'h2,
    MODE_CURR = 2'h3
  } mode_t;

  typedef struct packed {
    logic sclk_d;
    logic cs_n_d;
    logic clocked;
    logic sdo;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] inreg;
    logic [WORD_W-1:0] act;
    logic tripped;
    logic clamp_v;
    logic clamp_c;
    logic cmp_en;
    logic meas_en;
    logic ext;
    logic warn_n;
  } st_t;

  // Any write of the active word from the link or load also ends a thermal trip
  function automatic st_t put_active(input st_t s,
                                     input logic [WORD_W-1:0] w);
    put_active = s;
    put_active.act = w;
    put_active.tripped = 1'b0;
  endfunction

  st_t st_r;
  st_t st_nxt;
  logic [4:0] pins;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic load_n_s;
  logic meas_pin_n_s;
  logic [1:0] temp_s;
  mode_t mode;

  // ==========================================================
  // Pin sampling
  // Select, load and float pins idle high; they cross inverted so that
  // the cleared synchroniser reads as idle and no false edge follows reset
  sync2 #(.W(5)) u_pins (
    .clk(clk),
    .rst_n(rst_n),
    .d({link.sclk, ~link.cs_n, link.sdi, ~link.load_n,
        ~measure_float_pin_n}),
    .q(pins)
  );
  sync2 #(.W(2)) u_temp (
    .clk(clk),
    .rst_n(rst_n),
    .d({temp_warn_band, temp_over}),
    .q(temp_s)
  );
  assign sclk_s = pins[4];
  assign cs_n_s = ~pins[3];
  assign sdi_s = pins[2];
  assign load_n_s = ~pins[1];
  assign meas_pin_n_s = ~pins[0];

  // ==========================================================
  // Registers and transfers
  always_comb begin
    logic [WORD_W-1:0] act_w;
    act_w = '0;
    st_nxt = st_r;
    st_nxt.sclk_d = sclk_s;
    st_nxt.cs_n_d = cs_n_s;

    // A select pulse must outlast one clock or the synchroniser can miss it
    if (!cs_n_s && st_r.cs_n_d) begin
      st_nxt.clocked = 1'b0;
    end

    // Edges outside the frame are dropped
    if (!cs_n_s && sclk_s && !st_r.sclk_d) begin
      st_nxt.shift = {st_r.shift[WORD_W-2:0], sdi_s};
      st_nxt.clocked = 1'b1;
    end
    if (!cs_n_s && !sclk_s && st_r.sclk_d) begin
      st_nxt.sdo = st_r.shift[WORD_W-1];
    end

    if (cs_n_s && !st_r.cs_n_d) begin
      if (!st_r.clocked) begin
        st_nxt = put_active(st_nxt, st_r.inreg);
      end else begin
        // 00 leaves both registers alone
        if (st_r.shift[BIT_XFER_INPUT]) begin
          st_nxt.inreg = st_r.shift;
          if (st_r.shift[BIT_XFER_ACTIVE] || !load_n_s) begin
            st_nxt = put_active(st_nxt, st_r.shift);
          end
        end else if (st_r.shift[BIT_XFER_ACTIVE]) begin
          st_nxt = put_active(st_nxt, st_r.inreg);
        end
      end
    end

    // Load is level sensitive: the active word follows input while low
    if (!load_n_s) begin
      st_nxt = put_active(st_nxt, st_nxt.inreg);
    end

    // ==========================================================
    // Thermal protection
    if (temp_s[0]) begin
      // Hot die resets active word; cooling alone never restores it
      st_nxt.act = WORD_RESET;
      st_nxt.inreg = WORD_RESET;
      st_nxt.tripped = 1'b1;
    end

    // ==========================================================
    // Decoded controls
    // Registered so that no output glitches while a transfer lands
    act_w = st_nxt.act;
    st_nxt.clamp_v = act_w[BIT_CLAMP_EN] && act_w[BIT_FORCE_KIND];
    st_nxt.clamp_c = act_w[BIT_CLAMP_EN] && act_w[BIT_FORCE_FLOAT_N]
                     && !act_w[BIT_FORCE_KIND];
    st_nxt.cmp_en = act_w[BIT_CMP_FLOAT_N];
    st_nxt.meas_en = act_w[BIT_MEAS_FLOAT_N] && meas_pin_n_s;
    st_nxt.ext = act_w[BIT_RANGE_HI];
    st_nxt.warn_n = !temp_s[1];
  end

  // Edge detectors reset to the idle levels of their pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.sclk_d <= 1'b0;
      st_r.cs_n_d <= 1'b1;
      st_r.warn_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // Mode decode
  assign mode = mode_t'({st_r.act[BIT_FORCE_FLOAT_N],
                         st_r.act[BIT_FORCE_KIND]});
  assign force_kind_select = mode;
  assign link.sdo = st_r.sdo;
  assign active_word = st_r.act;
  assign clamp_volt_en = st_r.clamp_v;
  assign clamp_curr_en = st_r.clamp_c;
  assign cmp_out_en = st_r.cmp_en;
  assign meas_out_en = st_r.meas_en;
  assign range_sel = st_r.act[BIT_RANGE_HI:BIT_RANGE_LO];
  assign external_amp_select = st_r.ext;
  assign thermal_warning_n = st_r.warn_n;
  assign thermal_tripped = st_r.tripped;
endmodule

// ===== rtl/supply_host.sv
// Host end: shifts one 18-bit word per accepted request, then optional load pulse.
// Assumes the user side is on clk; sdo is sampled through two flops.
`timescale 1ns/1ps
module supply_host
  import supply_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  supply_link_if.host link,
  input wire logic req,
  input wire logic [WORD_W-1:0] req_word,
  input wire logic req_load,
  output logic busy,
  output logic done,
  output logic [WORD_W-1:0] rd_word,
  output logic range_refused
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOW = 3'h1,
    ST_HIGH = 3'h3,
    ST_END = 3'h2,
    ST_GAP = 3'h6,
    ST_LOAD = 3'h7
  } state_t;

  typedef struct packed {
    state_t st;
    logic [TIM_W-1:0] tim;
    logic [CNT_W-1:0] cnt;
    logic [WORD_W-1:0] sh;
    logic [WORD_W-1:0] rx;
    logic load;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic load_n;
    logic busy;
    logic done;
    logic refused;
    logic [2:0] range;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  logic [0:0] sdo_s;

  sync2 #(.W(1)) u_sdo (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.sdo),
    .q(sdo_s)
  );

  // Same or neighbouring internal ranges, 3 and 0 counting as neighbours, or entering/leaving external
  function automatic logic range_ok(input logic [2:0] a,
                                    input logic [2:0] b);
    logic [1:0] d;
    d = a[1:0] - b[1:0];
    range_ok = a[2] || b[2] || (a == b) || d == 2'h1 || d == 2'h3;
  endfunction

  // ==========================================================
  // Frame sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.tim = st_r.tim - TIM_W'(1);
    unique case (st_r.st)
      ST_IDLE: begin
        st_nxt.tim = st_r.tim;
        st_nxt.refused = 1'b0;
        if (req) begin
          // One range step per word; each accepted input word ends prior step
          if (req_word[BIT_XFER_INPUT] &&
              !range_ok(req_word[BIT_RANGE_HI:BIT_RANGE_LO], st_r.range)) begin
            st_nxt.refused = 1'b1;
            st_nxt.done = 1'b1;
          end else begin
            st_nxt.st = ST_LOW;
            st_nxt.sh = req_word;
            st_nxt.load = req_load;
            st_nxt.cnt = '0;
            st_nxt.cs_n = 1'b0;
            st_nxt.sdi = req_word[WORD_W-1];
            st_nxt.busy = 1'b1;
            st_nxt.tim = HALF_SCLK_TOP;
            if (req_word[BIT_XFER_INPUT]) begin
              st_nxt.range = req_word[BIT_RANGE_HI:BIT_RANGE_LO];
            end
          end
        end
      end
      ST_LOW: begin
        if (st_r.tim == '0) begin
          st_nxt.sclk = 1'b1;
          st_nxt.rx = {st_r.rx[WORD_W-2:0], sdo_s[0]};
          st_nxt.st = ST_HIGH;
          st_nxt.tim = HALF_SCLK_TOP;
        end
      end
      ST_HIGH: begin
        if (st_r.tim == '0) begin
          st_nxt.sclk = 1'b0;
          st_nxt.tim = HALF_SCLK_TOP;
          if (st_r.cnt == LAST_BIT) begin
            st_nxt.st = ST_END;
          end else begin
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
            st_nxt.sh = {st_r.sh[WORD_W-2:0], 1'b0};
            st_nxt.sdi = st_r.sh[WORD_W-2];
            st_nxt.st = ST_LOW;
          end
        end
      end
      ST_END: begin
        if (st_r.tim == '0) begin
          st_nxt.cs_n = 1'b1;
          st_nxt.st = ST_GAP;
          st_nxt.tim = CS_GAP_TOP;
        end
      end
      ST_GAP: begin
        if (st_r.tim == '0) begin
          if (st_r.load) begin
            st_nxt.load_n = 1'b0;
            st_nxt.load = 1'b0;
            st_nxt.tim = CS_GAP_TOP;
            st_nxt.st = ST_LOAD;
          end else begin
            // Next word only after gap: range change settled
            st_nxt.st = ST_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
          end
        end
      end
      ST_LOAD: begin
        if (st_r.tim == '0) begin
          st_nxt.load_n = 1'b1;
          st_nxt.tim = CS_GAP_TOP;
          st_nxt.st = ST_GAP;
        end
      end
      default: begin
        st_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.st <= ST_IDLE;
      st_r.cs_n <= 1'b1;
      st_r.load_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.sclk = st_r.sclk;
  assign link.cs_n = st_r.cs_n;
  assign link.sdi = st_r.sdi;
  assign link.load_n = st_r.load_n;
  assign busy = st_r.busy;
  assign done = st_r.done;
  assign rd_word = st_r.rx;
  assign range_refused = st_r.refused;
endmodule

// ===== testbench/supply_link_sva.sv
// Checker for the framing of the serial link between host and supply.
// Assumes the link pins are sampled on the system clock of the bench.
`timescale 1ns/1ps
module supply_link_sva
  import supply_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic load_n
);
  // ==========================================================
  // Serial clock rises counted within one frame
  logic sclk_r;
  logic [CNT_W-1:0] bits_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_r <= 1'b0;
      bits_r <= '0;
    end else begin
      sclk_r <= sclk;
      if (cs_n)
        bits_r <= '0;
      else if (sclk && !sclk_r)
        bits_r <= bits_r + CNT_W'(1);
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_half_low;
    !sclk [*8];
  endsequence
  sequence s_load_low;
    !load_n [*8] ##1 !load_n ##1 !load_n;
  endsequence
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  a_cs_lead: assert property ($fell(cs_n) |-> s_half_low)
    else $error("serial clock rose too soon after select");
  a_sclk_low: assert property ($fell(sclk) |-> s_half_low)
    else $error("serial clock low phase too short");
  a_sclk_high: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase wrong length");
  a_sdi_steady: assert property (sclk |-> $stable(sdi))
    else $error("serial data changed while clock high");
  a_frame_bits: assert property ($rose(cs_n) |-> bits_r == CNT_W'(WORD_W))
    else $error("frame did not carry a whole word");
  a_gap_after: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap after frame too short");
  a_load_width: assert property ($fell(load_n) |-> s_load_low ##1 load_n)
    else $error("load strobe width wrong");
  a_load_outside: assert property (!load_n |-> cs_n)
    else $error("load strobe inside a frame");
endmodule

// ===== testbench/tb.sv
// Bench: host and supply ends joined over the link, checked word by word.
// Assumes a 100 MHz clk; thermal and float pins are driven from here.
`timescale 1ns/1ps
module tb
  import supply_ctl_pkg::*;
;
  logic clk, rst_n, req, req_load, busy, done, refused;
  logic pin_n, warn, over, clamp_v, clamp_c, cmp_en, meas_en, ext;
  logic warn_n, tripped;
  logic [WORD_W-1:0] req_word, rd_word, act;
  logic [2:0] rsel;
  logic [1:0] kind;
  int miscompares, check_count;
  supply_link_if link();
  supply_host i_supply_host (.clk(clk), .rst_n(rst_n), .link(link.host),
    .req(req), .req_word(req_word), .req_load(req_load), .busy(busy),
    .done(done), .rd_word(rd_word), .range_refused(refused));
  supply_dev i_supply_dev (.clk(clk), .rst_n(rst_n), .link(link.dev),
    .measure_float_pin_n(pin_n), .temp_warn_band(warn), .temp_over(over),
    .active_word(act), .clamp_volt_en(clamp_v), .clamp_curr_en(clamp_c),
    .cmp_out_en(cmp_en), .meas_out_en(meas_en), .range_sel(rsel),
    .external_amp_select(ext), .force_kind_select(kind),
    .thermal_warning_n(warn_n), .thermal_tripped(tripped));
  supply_link_sva i_supply_link_sva (.clk(clk), .rst_n(rst_n),
    .sclk(link.sclk), .cs_n(link.cs_n), .sdi(link.sdi),
    .load_n(link.load_n));
  // ==========================================================
  // Tasks
  task automatic check(input logic [WORD_W-1:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Decoded outputs packed as kind, clamps, external, range, floats
  task automatic outs(input logic [WORD_W-1:0] exp);
    check(WORD_W'({kind, clamp_v, clamp_c, ext, rsel, cmp_en, meas_en}),
          exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Done is awaited under a bound and follows any load pulse; the fixed tail covers sync
  task automatic send(input logic [WORD_W-1:0] w, input logic ld, rf);
    int n;
    @(negedge clk);
    req = 1'b1;
    req_word = w;
    req_load = ld;
    @(negedge clk);
    req = 1'b0;
    check(WORD_W'(busy), WORD_W'(!rf));
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    check(WORD_W'(refused), WORD_W'(rf));
    check(WORD_W'(busy), 18'h00000);
    wait_n(40);
  endtask
  // ==========================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    req_load = 1'b0;
    req_word = '0;
    pin_n = 1'b1;
    warn = 1'b0;
    over = 1'b0;
    miscompares = 0;
    check_count = 0;
    wait_n(8);
    rst_n = 1'b1;
    wait_n(4);
    check(act, WORD_RESET);
    check(WORD_W'(warn_n), 18'h00001);
    send(18'h20dc3, 1'b0, 1'b0);
    check(act, 18'h20dc3);
    outs(18'h00387);
    send(18'h15554, 1'b0, 1'b0);
    check(act, 18'h20dc3);
    check(rd_word, 18'h20dc3);
    send(18'h02502, 1'b0, 1'b0);
    check(act, 18'h20dc3);
    check(rd_word, 18'h15554);
    send(18'h00001, 1'b0, 1'b0);
    check(act, 18'h02502);
    outs(18'h00270);
    send(18'h20dc2, 1'b1, 1'b0);
    check(act, 18'h20dc2);
    pin_n = 1'b0;
    wait_n(6);
    check(WORD_W'(meas_en), 18'h00000);
    pin_n = 1'b1;
    wait_n(6);
    check(WORD_W'(meas_en), 18'h00001);
    send(18'h01802, 1'b0, 1'b1);
    check(act, 18'h20dc2);
    warn = 1'b1;
    wait_n(6);
    check(WORD_W'(warn_n), 18'h00000);
    warn = 1'b0;
    over = 1'b1;
    wait_n(6);
    over = 1'b0;
    wait_n(10);
    check(act, 18'h00000);
    check(WORD_W'(tripped), 18'h00001);
    check(WORD_W'(kind), 18'h00000);
    send(18'h20dc3, 1'b0, 1'b0);
    check(act, 18'h20dc3);
    check(WORD_W'(tripped), 18'h00000);
    report_and_stop();
  end
endmodule
